//--- rtl/pcsc_pkg.sv
// shared constants and types for the 16-bit card socket strobe control
`default_nettype none
package pcsc_pkg;
  // ===========================================================
  // strobe timing, in nanoseconds and clock cycles
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned SETUP_NS        = 30;
  localparam int unsigned STROBE_MIN_NS   = 150;
  localparam int unsigned HOLD_NS         = 30;
  localparam int unsigned RESET_PULSE_NS  = 10000;
  localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_MIN_CYC  =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 16;
  // ===========================================================
  // access kinds
  localparam logic [1:0] KIND_MEM_RD = 2'h0;
  localparam logic [1:0] KIND_MEM_WR = 2'h1;
  localparam logic [1:0] KIND_IO_RD  = 2'h2;
  localparam logic [1:0] KIND_IO_WR  = 2'h3;
  // ===========================================================
  // cycle sequencer states
  typedef enum logic [2:0] {
    PCSC_IDLE,
    PCSC_SETUP,
    PCSC_STROBE,
    PCSC_HOLD,
    PCSC_DONE
  } pcsc_state_t;
endpackage : pcsc_pkg
`default_nettype wire

//--- rtl/pcsc_sync3.sv
// three-flop synchroniser with agreement filter for one card pin
`default_nettype none
module pcsc_sync3 (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // pin and filtered level
  input  wire logic pin_in,
  input  wire logic rst_val_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  // ===========================================================
  // first flop feeds only the second
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      lvl_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end
  // rst_val_in only documents intent; pins idle high after reset
  assign level_out = lvl_reg | (rst_val_in & 1'b0);
endmodule : pcsc_sync3
`default_nettype wire

//--- rtl/pcsc_reset_gen.sv
// card hard-reset pulse generator
`default_nettype none
module pcsc_reset_gen
  import pcsc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = RESET_PULSE_CYC
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // request and card reset
  input  wire logic start_in,
  output logic      card_reset_out,
  output logic      busy_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic             rst_reg;
  // ===========================================================
  // pulse held for a full count, restarted by a new request
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // card stays in reset for a full pulse after controller reset
      cnt_reg <= CNT_W'(PULSE_CYC);
      rst_reg <= 1'b1;
    end else if (start_in) begin
      cnt_reg <= CNT_W'(PULSE_CYC);
      rst_reg <= 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
      rst_reg <= 1'b1;
    end else begin
      rst_reg <= 1'b0;
    end
  end
  assign card_reset_out = rst_reg;
  assign busy_out       = rst_reg;
endmodule : pcsc_reset_gen
`default_nettype wire

//--- rtl/pcsc_socket_ctrl.sv
// 16-bit card socket strobe and handshake control
// Operation
// - io read cycle drives io_read_strobe so the card outputs data
// - io write cycle drives io_write_strobe low to latch data
// - memory read drives output-enable low for card read data
// - memory write uses write-enable low to latch data
// - shared line means ready only in memory-only mode
// - high on interrupt line means no interrupt pending
// - attribute select stays high for common memory accesses
// - attribute select low picks attribute memory or io space
// - card reset output forces a hard card reset
// - no strobe ends while wait is asserted; setup and hold ignore wait
// - io mode reads write-protect pin as wide port indication
// - even_byte_enable picks even bytes, odd_byte_enable odd bytes
`default_nettype none
module pcsc_socket_ctrl
  import pcsc_pkg::*;
#(
  parameter int unsigned RST_CYC = RESET_PULSE_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // host request side
  input  wire logic       req_in,
  input  wire logic [1:0] req_kind_in,
  input  wire logic       req_attr_in,
  input  wire logic       req_odd_in,
  input  wire logic       req_wide_in,
  input  wire logic       io_mode_in,
  input  wire logic       card_reset_req_in,
  output logic            busy_out,
  output logic            done_out,
  output logic            ack_seen_out,
  // host status side
  output logic            card_ready_out,
  output logic            card_irq_out,
  output logic            write_protect_out,
  output logic            wide_port_out,
  output logic            card_reset_active_out,
  // card pins, active low strobes
  output logic            io_read_strobe_n_out,
  output logic            io_write_strobe_n_out,
  output logic            oe_n_out,
  output logic            we_n_out,
  output logic            attr_sel_n_out,
  output logic            even_byte_enable_n_out,
  output logic            odd_byte_enable_n_out,
  output logic            card_reset_out,
  input  wire logic       wait_n_in,
  input  wire logic       ready_irq_in,
  input  wire logic       write_protect_in,
  input  wire logic       input_acknowledge_n_in
);
  pcsc_state_t       state_reg;
  pcsc_state_t       state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [1:0]        kind_reg;
  logic              attr_reg;
  logic              odd_reg;
  logic              wide_reg;
  logic              io_rd_n_reg;
  logic              io_wr_n_reg;
  logic              oe_n_reg;
  logic              we_n_reg;
  logic              reg_n_reg;
  logic              even_n_reg;
  logic              odd_n_reg;
  logic              done_reg;
  logic              busy_reg;
  logic              ack_reg;
  logic              ready_reg;
  logic              irq_reg;
  logic              wp_reg;
  logic              wide_port_reg;
  logic              wait_s;
  logic              shared_s;
  logic              wp_s;
  logic              in_ack_s;
  logic              crst;
  logic              crst_busy;
  // ===========================================================
  // pin synchronisers
  pcsc_sync3 u_sync_wait (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .pin_in     (wait_n_in),
    .rst_val_in (1'b1),
    .level_out  (wait_s)
  );
  pcsc_sync3 u_sync_rdy (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .pin_in     (ready_irq_in),
    .rst_val_in (1'b1),
    .level_out  (shared_s)
  );
  pcsc_sync3 u_sync_wp (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .pin_in     (write_protect_in),
    .rst_val_in (1'b1),
    .level_out  (wp_s)
  );
  pcsc_sync3 u_sync_ack (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .pin_in     (input_acknowledge_n_in),
    .rst_val_in (1'b1),
    .level_out  (in_ack_s)
  );
  // ===========================================================
  // card hard reset
  pcsc_reset_gen #(
    .PULSE_CYC (RST_CYC)
  ) u_rst (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .start_in       (card_reset_req_in),
    .card_reset_out (crst),
    .busy_out       (crst_busy)
  );
  // ===========================================================
  // sequencer decode
  wire wait_active = ~wait_s;
  wire take_req    = (state_reg == PCSC_IDLE) & req_in & ~crst_busy;
  wire min_done    = (cnt_reg == '0);
  wire strobe_on   = (state_next == PCSC_STROBE);
  wire addr_on     = (state_next == PCSC_SETUP) | strobe_on | (state_next == PCSC_HOLD);
  // on the take edge the captured fields are still stale, so use the request
  wire [1:0] kind_now = take_req ? req_kind_in : kind_reg;
  wire attr_now    = take_req ? req_attr_in : attr_reg;
  wire odd_now     = take_req ? req_odd_in : odd_reg;
  wire wide_now    = take_req ? req_wide_in : wide_reg;
  wire is_rd_io    = (kind_now == KIND_IO_RD);
  wire is_wr_io    = (kind_now == KIND_IO_WR);
  wire is_rd_mem   = (kind_now == KIND_MEM_RD);
  wire is_wr_mem   = (kind_now == KIND_MEM_WR);
  wire is_io       = is_rd_io | is_wr_io;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      PCSC_IDLE: begin
        if (take_req) begin
          state_next = PCSC_SETUP;
          cnt_next   = CNT_W'(SETUP_CYC - 1);
        end
      end
      PCSC_SETUP: begin
        if (min_done) begin
          state_next = PCSC_STROBE;
          cnt_next   = CNT_W'(STROBE_MIN_CYC - 1);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      PCSC_STROBE: begin
        // strobe stays until minimum width passed and wait released
        if (!min_done) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (!wait_active) begin
          state_next = PCSC_HOLD;
          cnt_next   = CNT_W'(HOLD_CYC - 1);
        end
      end
      PCSC_HOLD: begin
        if (min_done) begin
          state_next = PCSC_DONE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      PCSC_DONE: begin
        state_next = PCSC_IDLE;
      end
      default: begin
        state_next = PCSC_IDLE;
      end
    endcase
  end
  // ===========================================================
  // sequencer and request capture
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= PCSC_IDLE;
      cnt_reg   <= '0;
      kind_reg  <= KIND_MEM_RD;
      attr_reg  <= 1'b0;
      odd_reg   <= 1'b0;
      wide_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (take_req) begin
        kind_reg <= req_kind_in;
        attr_reg <= req_attr_in;
        odd_reg  <= req_odd_in;
        wide_reg <= req_wide_in;
      end
    end
  end
  // ===========================================================
  // card strobes, all registered; io space always selected with reg low
  wire io_rd_n_next = ~(strobe_on & is_rd_io);
  wire io_wr_n_next = ~(strobe_on & is_wr_io);
  wire oe_n_next    = ~(strobe_on & is_rd_mem);
  wire we_n_next    = ~(strobe_on & is_wr_mem);
  wire reg_n_next   = ~(addr_on & (attr_now | is_io));
  wire wide_go      = wide_now & (~is_io | ~wp_s);
  wire even_n_next  = ~(addr_on & (~odd_now | wide_go));
  wire odd_n_next   = ~(addr_on & (odd_now | wide_go));

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      io_rd_n_reg <= 1'b1;
      io_wr_n_reg <= 1'b1;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      reg_n_reg   <= 1'b1;
      even_n_reg  <= 1'b1;
      odd_n_reg   <= 1'b1;
    end else begin
      io_rd_n_reg <= io_rd_n_next;
      io_wr_n_reg <= io_wr_n_next;
      oe_n_reg    <= oe_n_next;
      we_n_reg    <= we_n_next;
      reg_n_reg   <= reg_n_next;
      even_n_reg  <= even_n_next;
      odd_n_reg   <= odd_n_next;
    end
  end
  // ===========================================================
  // host handshake and card status
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_reg      <= 1'b0;
      busy_reg      <= 1'b0;
      ack_reg       <= 1'b0;
      ready_reg     <= 1'b0;
      irq_reg       <= 1'b0;
      wp_reg        <= 1'b0;
      wide_port_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == PCSC_DONE);
      busy_reg <= (state_next != PCSC_IDLE) | crst_busy;
      if (take_req) begin
        ack_reg <= 1'b0;
      end else if (state_reg == PCSC_STROBE && is_rd_io && !in_ack_s) begin
        ack_reg <= 1'b1;
      end
      ready_reg     <= ~io_mode_in & shared_s;
      irq_reg       <= io_mode_in & ~shared_s;
      wp_reg        <= ~io_mode_in & wp_s;
      wide_port_reg <= io_mode_in & ~wp_s;
    end
  end

  assign io_read_strobe_n_out   = io_rd_n_reg;
  assign io_write_strobe_n_out  = io_wr_n_reg;
  assign oe_n_out               = oe_n_reg;
  assign we_n_out               = we_n_reg;
  assign attr_sel_n_out         = reg_n_reg;
  assign even_byte_enable_n_out = even_n_reg;
  assign odd_byte_enable_n_out  = odd_n_reg;
  assign card_reset_out         = crst;
  assign card_reset_active_out  = crst;
  assign busy_out               = busy_reg;
  assign done_out               = done_reg;
  assign ack_seen_out           = ack_reg;
  assign card_ready_out         = ready_reg;
  assign card_irq_out           = irq_reg;
  assign write_protect_out      = wp_reg;
  assign wide_port_out          = wide_port_reg;
  // ===========================================================
  // checks
  sequence s_strobe_low;
    (!io_rd_n_reg || !io_wr_n_reg || !oe_n_reg || !we_n_reg);
  endsequence
  a_one_strobe: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $onehot0({~io_rd_n_reg, ~io_wr_n_reg, ~oe_n_reg, ~we_n_reg}))
    else $error("more than one strobe active");
  a_io_rd_kind: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !io_rd_n_reg |-> kind_reg == KIND_IO_RD && !reg_n_reg)
    else $error("io read strobe on wrong cycle");
  a_io_wr_kind: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !io_wr_n_reg |-> kind_reg == KIND_IO_WR && !reg_n_reg)
    else $error("io write strobe on wrong cycle");
  a_oe_kind: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !oe_n_reg |-> kind_reg == KIND_MEM_RD)
    else $error("output enable on wrong cycle");
  a_we_kind: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !we_n_reg |-> kind_reg == KIND_MEM_WR)
    else $error("write enable on wrong cycle");
  a_ready_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    card_ready_out |-> $past(~io_mode_in))
    else $error("ready reported in io mode");
  a_irq_level: assert property (@(posedge clk_in) disable iff (!resetn_in)
    card_irq_out |-> $past(~shared_s))
    else $error("interrupt reported on high line");
  a_common_reg: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_strobe_low and (state_reg == PCSC_STROBE && !attr_reg && !is_io)) |-> reg_n_reg)
    else $error("attribute select on common access");
  a_wait_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == PCSC_STROBE && wait_active) |=> state_reg == PCSC_STROBE)
    else $error("cycle left while wait asserted");
  a_strobe_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == PCSC_STROBE && min_done && !wait_active) |=> ##[1:40] done_reg)
    else $error("cycle not closed after wait release");
  a_wide_map: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wide_port_out |-> $past(io_mode_in))
    else $error("wide port shown in memory mode");
endmodule : pcsc_socket_ctrl
`default_nettype wire

//--- sim/pcsc_card_model.sv
// behavioural 16-bit card facing the socket strobes
`default_nettype none
module pcsc_card_model (
  // clock and socket pins
  input  wire logic       clk_in,
  input  wire logic       io_read_strobe_n_in,
  input  wire logic       io_write_strobe_n_in,
  input  wire logic       oe_n_in,
  input  wire logic       we_n_in,
  input  wire logic       card_reset_in,
  // behaviour set by the bench
  input  wire logic       io_mode_in,
  input  wire logic [7:0] wait_cyc_in,
  input  wire logic       ready_in,
  input  wire logic       irq_in,
  input  wire logic       wp_in,
  // card pins
  output logic            wait_n_out,
  output logic            ready_irq_out,
  output logic            write_protect_out,
  output logic            input_acknowledge_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int   wait_cnt  = 0;
  logic any_n_reg = 1'b1;
  wire  any_n     = io_read_strobe_n_in & io_write_strobe_n_in & oe_n_in & we_n_in;
  // ==========================================================
  // wait stretch, loaded one cycle after a strobe falls
  always @(posedge clk_in) begin
    any_n_reg <= any_n;
    if (any_n_reg && !any_n) wait_cnt <= wait_cyc_in;
    else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
  end
  assign wait_n_out = (wait_cnt == 0);
  // ==========================================================
  // shared line: ready in memory mode, low-true request in io mode
  assign ready_irq_out = io_mode_in ? !irq_in : (ready_in & !card_reset_in);
  // every address counts as decoded, so the wide flag is a plain level
  assign write_protect_out = io_mode_in ? !wp_in : wp_in;
  assign input_acknowledge_n_out = io_read_strobe_n_in;
endmodule : pcsc_card_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the socket strobe control
`default_nettype none
module testbench
  import pcsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST = 8;
  logic       clk_in, resetn_in, req_in, req_attr_in, req_odd_in, req_wide_in;
  logic       io_mode_in, card_reset_req_in, m_ready, m_irq, m_wp;
  logic [1:0] req_kind_in;
  logic [7:0] m_wait;
  logic       busy_out, done_out, ack_seen_out, card_ready_out, card_irq_out;
  logic       write_protect_out, wide_port_out, card_reset_active_out, card_reset_out;
  logic       ior_n, iow_n, oe_n, we_n, attr_n, even_n, odd_n;
  logic       wait_n, rdy_irq, wp_pin, ack_n;
  int         n_mismatch, check_count, seed, n, i;
  always #4 clk_in = ~clk_in;
  pcsc_socket_ctrl #(.RST_CYC(RST)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .req_in(req_in), .req_kind_in(req_kind_in),
    .req_attr_in(req_attr_in), .req_odd_in(req_odd_in), .req_wide_in(req_wide_in),
    .io_mode_in(io_mode_in), .card_reset_req_in(card_reset_req_in), .busy_out(busy_out),
    .done_out(done_out), .ack_seen_out(ack_seen_out), .card_ready_out(card_ready_out),
    .card_irq_out(card_irq_out), .write_protect_out(write_protect_out),
    .wide_port_out(wide_port_out), .card_reset_active_out(card_reset_active_out),
    .io_read_strobe_n_out(ior_n), .io_write_strobe_n_out(iow_n), .oe_n_out(oe_n),
    .we_n_out(we_n), .attr_sel_n_out(attr_n), .even_byte_enable_n_out(even_n),
    .odd_byte_enable_n_out(odd_n), .card_reset_out(card_reset_out), .wait_n_in(wait_n),
    .ready_irq_in(rdy_irq), .write_protect_in(wp_pin), .input_acknowledge_n_in(ack_n));
  pcsc_card_model i_card (
    .clk_in(clk_in), .io_read_strobe_n_in(ior_n), .io_write_strobe_n_in(iow_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .card_reset_in(card_reset_out), .io_mode_in(io_mode_in),
    .wait_cyc_in(m_wait), .ready_in(m_ready), .irq_in(m_irq), .wp_in(m_wp),
    .wait_n_out(wait_n), .ready_irq_out(rdy_irq), .write_protect_out(wp_pin),
    .input_acknowledge_n_out(ack_n));
  // ==========================================================
  // reporting
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // bounded count of cycles with card reset still high
  task automatic reset_len(output int len);
    len = 0;
    while (card_reset_out === 1'b1 && len < 64) begin
      @(posedge clk_in);
      #1;
      len++;
    end
    if (len >= 64) begin
      n_mismatch++;
      test_done();
    end
  endtask : reset_len
  // ==========================================================
  // one host cycle against the card model
  task automatic run_cycle(input int kind, input logic attr, odd, wide, wp, input int wcyc);
    int         lows [4];
    int         k, emin;
    logic       al, el, ol, weff;
    logic [3:0] s;
    lows = '{0, 0, 0, 0};
    al = 1'b0;
    el = 1'b0;
    ol = 1'b0;
    weff = wide & ((kind < 2) | wp);
    @(posedge clk_in);
    io_mode_in <= (kind >= 2);
    m_wait <= wcyc[7:0];
    m_wp <= wp;
    // wide flag needs the pin synchroniser settled before the take
    repeat (8) @(posedge clk_in);
    req_in <= 1'b1;
    req_kind_in <= kind[1:0];
    req_attr_in <= attr;
    req_odd_in <= odd;
    req_wide_in <= wide;
    for (k = 0; k < 400; k++) begin
      @(posedge clk_in);
      if (busy_out === 1'b1) req_in <= 1'b0;
      #1;
      s = {iow_n, ior_n, we_n, oe_n};
      for (int j = 0; j < 4; j++) if (s[j] === 1'b0) lows[j]++;
      if (attr_n === 1'b0) al = 1'b1;
      if (even_n === 1'b0) el = 1'b1;
      if (odd_n === 1'b0) ol = 1'b1;
      if (done_out === 1'b1) break;
    end
    if (k >= 400) begin
      n_mismatch++;
      test_done();
    end
    emin = (wcyc > STROBE_MIN_CYC) ? wcyc : STROBE_MIN_CYC;
    for (int j = 0; j < 4; j++) if (j != kind) chk("idle strobe", 0, lows[j]);
    chk("strobe width", 1, lows[kind] >= emin && lows[kind] <= emin + 8);
    chk("attr select", (kind >= 2) | attr, al);
    chk("even enable", weff | !odd, el);
    chk("odd enable", weff | odd, ol);
    chk("ack seen", kind == 2, ack_seen_out);
  endtask : run_cycle
  // ==========================================================
  // main sequence
  initial begin
    {clk_in, resetn_in, req_in, req_attr_in, req_odd_in, req_wide_in} = '0;
    {io_mode_in, card_reset_req_in, m_irq, m_wp, req_kind_in} = '0;
    m_ready = 1'b1;
    m_wait = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    seed = 32'h3ddc57ce;
    repeat (8) @(posedge clk_in);
    chk("reset held", 1, card_reset_out);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    reset_len(n);
    chk("reset length", 1, n >= RST - 1 && n <= RST + 2);
    chk("reset active off", 0, card_reset_active_out);
    $display("test power_on_reset done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk_in);
      io_mode_in <= i[1];
      m_ready <= i[0];
      m_irq <= i[0];
      m_wp <= i[0];
      repeat (10) @(posedge clk_in);
      #1;
      if (i[1]) begin
        chk("irq", i[0], card_irq_out);
        chk("wide port", i[0], wide_port_out);
        chk("ready in io", 0, card_ready_out);
      end else begin
        chk("ready", i[0], card_ready_out);
        chk("write protect", i[0], write_protect_out);
      end
    end
    $display("test status_levels done");
    for (i = 0; i < 24; i++)
      run_cycle(i % 4, $random(seed), $random(seed), $random(seed), $random(seed),
                (i < 4) ? 0 : ($random(seed) & 31));
    $display("test host_cycles done");
    @(posedge clk_in);
    card_reset_req_in <= 1'b1;
    @(posedge clk_in);
    card_reset_req_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("card reset on", 1, card_reset_out);
    chk("card reset active", 1, card_reset_active_out);
    reset_len(n);
    chk("card reset length", 1, n >= RST - 2 && n <= RST + 2);
    run_cycle(2, 1'b0, 1'b1, 1'b1, 1'b1, 40);
    $display("test card_reset done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
